//--- hw/sms_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none

module sms_clkdiv (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic dbl,
    input wire logic [1:0] rate,
    output logic tick
);

    logic [6:0] half;
    logic [6:0] cnt_q;

    always_comb begin
        unique case ({dbl, rate})
            3'b000: half = sms_pkg::HALF_DIV4;
            3'b001: half = sms_pkg::HALF_DIV16;
            3'b010: half = sms_pkg::HALF_DIV64;
            3'b011: half = sms_pkg::HALF_DIV128;
            3'b100: half = sms_pkg::HALF_DIV2;
            3'b101: half = sms_pkg::HALF_DIV8;
            3'b110: half = sms_pkg::HALF_DIV32;
            3'b111: half = sms_pkg::HALF_DIV64;
        endcase
    end

    // One-cycle enable per half period of the serial clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 7'h00;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_q <= 7'h00;
            tick <= 1'b0;
        end else if (cnt_q == half - 7'h01) begin
            cnt_q <= 7'h00;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            tick <= 1'b0;
        end
    end

endmodule : sms_clkdiv

`default_nettype wire

//--- hw/sms_pkg.sv
package sms_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h2;
    localparam logic [1:0] ADDR_DIR = 2'h3;

    // serial_control_reg fields
    localparam int CTRL_IRQ_EN = 7;
    localparam int CTRL_ENABLE = 6;
    localparam int CTRL_ORDER = 5;
    localparam int CTRL_MASTER = 4;
    localparam int CTRL_CLOCK_IDLE_LEVEL = 3;
    localparam int CTRL_CLOCK_SAMPLE_EDGE = 2;
    localparam int CTRL_RATE_HI = 1;
    localparam int CTRL_RATE_LO = 0;

    // serial_status_reg fields
    localparam int STAT_DONE = 7;
    localparam int STAT_WRITE_COLLISION_FLAG = 6;
    localparam int STAT_DBL = 0;

    // Pin direction register fields
    localparam int DIR_MOSI = 0;
    localparam int DIR_MISO = 1;
    localparam int DIR_SCK = 2;
    localparam int DIR_SS = 3;
    localparam int DIR_SS_LEVEL = 4;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h10;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Half periods of the master clock in system cycles, index {dbl, rate}
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [6:0] HALF_DIV2 = 7'h01;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV32 = 7'h10;

    // Clock edges in one byte, and pipeline depth of the input synchroniser
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    localparam int SYNC_DEPTH = 2;

    typedef enum logic [1:0] {
        SMS_M_IDLE = 2'b01,
        SMS_M_RUN = 2'b10
    } sms_mstate_t;

endpackage : sms_pkg

//--- hw/sms_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sms_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // Constant reset values; the first stage feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : sms_sync

`default_nettype wire

//--- hw/sms_top.sv
`timescale 1ns/1ps
`default_nettype none

module sms_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and pin inputs

    logic [7:0] ctrl_q;
    logic [7:0] dir_q;
    logic dbl_q;
    logic done_q;
    logic write_collision_flag_q;
    logic armed_q;
    logic [7:0] tx_q;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_buf_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] tx_idx_q;
    logic dout_q;
    logic sck_q;
    logic [4:0] edge_cnt_q;
    logic got_q;
    logic [sms_pkg::SYNC_DEPTH:0] samp_pipe_q;
    logic s_sck_prev_q;
    sms_pkg::sms_mstate_t mstate_q;

    logic [3:0] pins_sync;
    logic s_sck;
    logic s_mosi;
    logic s_miso;
    logic s_ss_n;

    sms_sync #(.WIDTH(4)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({sck_in, mosi_in, miso_in, ss_n_in}),
        .sync_out(pins_sync)
    );

    assign s_sck = pins_sync[3];
    assign s_mosi = pins_sync[2];
    assign s_miso = pins_sync[1];
    assign s_ss_n = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic enabled;
    logic is_master;
    logic clock_idle_level;
    logic clock_sample_edge;
    logic lsb_first;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_dir;
    logic rd_stat;
    logic data_access;
    logic slave_sel;
    logic busy;
    logic mode_fault;
    logic div_tick;
    logic tick;
    logic leading;
    logic m_setup;
    logic m_sample;
    logic s_edge;
    logic s_leading;
    logic s_setup;
    logic s_sample;
    logic shift_in;
    logic in_bit;
    logic [7:0] rx_next;
    logic byte_in;
    logic m_finish;
    logic start;
    logic done_set;
    logic cur_bit0;
    logic cur_bit;

    assign enabled = ctrl_q[sms_pkg::CTRL_ENABLE];
    assign is_master = ctrl_q[sms_pkg::CTRL_MASTER];
    assign clock_idle_level = ctrl_q[sms_pkg::CTRL_CLOCK_IDLE_LEVEL];
    assign clock_sample_edge = ctrl_q[sms_pkg::CTRL_CLOCK_SAMPLE_EDGE];
    assign lsb_first = ctrl_q[sms_pkg::CTRL_ORDER];

    assign wr_ctrl = wr && addr == sms_pkg::ADDR_CTRL;
    assign wr_stat = wr && addr == sms_pkg::ADDR_STAT;
    assign wr_data = wr && addr == sms_pkg::ADDR_DATA;
    assign wr_dir = wr && addr == sms_pkg::ADDR_DIR;
    assign rd_stat = rd && addr == sms_pkg::ADDR_STAT;
    assign data_access = (wr || rd) && addr == sms_pkg::ADDR_DATA;

    // Slave is active only while its select is low
    assign slave_sel = enabled && !is_master && !s_ss_n;
    assign busy = is_master ? (mstate_q == sms_pkg::SMS_M_RUN)
                            : (slave_sel && bit_cnt_q != 3'h0);
    assign mode_fault = enabled && is_master && !dir_q[sms_pkg::DIR_SS] && !s_ss_n;
    assign start = wr_data && enabled && is_master && !busy && !mode_fault;

    // Master edges: leading edge leaves the idle level
    assign leading = (sck_q == clock_idle_level);
    assign m_setup = tick && (leading == clock_sample_edge);
    assign m_sample = tick && (leading != clock_sample_edge);

    // Slave edges from the second synchroniser stage only
    assign s_edge = slave_sel && (s_sck != s_sck_prev_q);
    assign s_leading = (s_sck_prev_q == clock_idle_level);
    assign s_setup = s_edge && (s_leading == clock_sample_edge);
    assign s_sample = s_edge && (s_leading != clock_sample_edge);

    // Master waits out its own pin register and the synchroniser, so at the
    // fastest rate it still takes the bit from before the next setup edge
    assign shift_in = is_master ? samp_pipe_q[sms_pkg::SYNC_DEPTH] : s_sample;
    assign in_bit = is_master ? s_miso : s_mosi;
    assign rx_next = lsb_first ? {in_bit, rx_sh_q[7:1]} : {rx_sh_q[6:0], in_bit};
    assign byte_in = enabled && shift_in && bit_cnt_q == 3'h7;

    assign m_finish = mstate_q == sms_pkg::SMS_M_RUN && edge_cnt_q == sms_pkg::EDGES_PER_BYTE
                      && got_q && samp_pipe_q == '0;
    assign done_set = m_finish || (!is_master && byte_in) || mode_fault;

    assign cur_bit0 = lsb_first ? tx_q[0] : tx_q[7];
    assign cur_bit = lsb_first ? tx_q[tx_idx_q] : tx_q[3'h7 - tx_idx_q];

    // Divider output is registered; gate it so no seventeenth edge slips out
    assign tick = div_tick && mstate_q == sms_pkg::SMS_M_RUN
                  && edge_cnt_q != sms_pkg::EDGES_PER_BYTE;

    sms_clkdiv u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(mstate_q == sms_pkg::SMS_M_RUN && edge_cnt_q != sms_pkg::EDGES_PER_BYTE),
        .dbl(dbl_q),
        .rate({ctrl_q[sms_pkg::CTRL_RATE_HI], ctrl_q[sms_pkg::CTRL_RATE_LO]}),
        .tick(div_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control and direction registers

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= sms_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata;
        end else if (mode_fault) begin
            ctrl_q[sms_pkg::CTRL_MASTER] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_q <= sms_pkg::DIR_RESET;
            dbl_q <= 1'b0;
        end else begin
            if (wr_dir) begin
                dir_q <= wdata;
            end
            if (wr_stat) begin
                dbl_q <= wdata[sms_pkg::STAT_DBL];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: a set in the clearing cycle wins

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (rd_stat) begin
                armed_q <= done_q || write_collision_flag_q;
            end else if (data_access) begin
                armed_q <= 1'b0;
            end
            if (done_set) begin
                done_q <= 1'b1;
            end else if (armed_q && data_access) begin
                done_q <= 1'b0;
            end
            if (wr_data && busy) begin
                write_collision_flag_q <= 1'b1;
            end else if (armed_q && data_access) begin
                write_collision_flag_q <= 1'b0;
            end
        end
    end

    // Level interrupt: done flag gated by the interrupt enable, registered one cycle late
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= done_q && ctrl_q[sms_pkg::CTRL_IRQ_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master sequencer

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mstate_q <= sms_pkg::SMS_M_IDLE;
            edge_cnt_q <= 5'h00;
            sck_q <= 1'b0;
            got_q <= 1'b0;
        end else if (!enabled || !is_master || mode_fault) begin
            mstate_q <= sms_pkg::SMS_M_IDLE;
            edge_cnt_q <= 5'h00;
            sck_q <= clock_idle_level;
            got_q <= 1'b0;
        end else begin
            unique case (mstate_q)
                sms_pkg::SMS_M_IDLE: begin
                    sck_q <= clock_idle_level;
                    if (start) begin
                        mstate_q <= sms_pkg::SMS_M_RUN;
                        edge_cnt_q <= 5'h00;
                        got_q <= 1'b0;
                    end
                end
                sms_pkg::SMS_M_RUN: begin
                    if (tick) begin
                        sck_q <= ~sck_q;
                        edge_cnt_q <= edge_cnt_q + 5'h01;
                    end
                    if (byte_in) begin
                        got_q <= 1'b1;
                    end
                    if (m_finish) begin
                        mstate_q <= sms_pkg::SMS_M_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            samp_pipe_q <= '0;
        end else begin
            samp_pipe_q <= {samp_pipe_q[sms_pkg::SYNC_DEPTH-1:0], m_sample && is_master};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit side: single buffer, bit pointer moves on setup edges

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_q <= sms_pkg::DATA_RESET;
            tx_idx_q <= 3'h0;
            dout_q <= 1'b0;
        end else if (wr_data && enabled && !busy && !mode_fault) begin
            tx_q <= wdata;
            if (!clock_sample_edge) begin
                dout_q <= lsb_first ? wdata[0] : wdata[7];
                tx_idx_q <= 3'h1;
            end else begin
                tx_idx_q <= 3'h0;
            end
        end else if (!enabled || (!is_master && s_ss_n)) begin
            // Deselected slave holds its first bit ready
            dout_q <= cur_bit0;
            tx_idx_q <= clock_sample_edge ? 3'h0 : 3'h1;
        end else if ((is_master && m_setup) || (!is_master && s_setup)) begin
            dout_q <= cur_bit;
            tx_idx_q <= tx_idx_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive side: shifter plus a buffer overwritten only by a full byte

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_sh_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            s_sck_prev_q <= 1'b0;
        end else begin
            s_sck_prev_q <= s_sck;
            if (!enabled || (!is_master && s_ss_n) || start) begin
                bit_cnt_q <= 3'h0;
            end else if (shift_in) begin
                rx_sh_q <= rx_next;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_buf_q <= 8'h00;
        end else if (byte_in) begin
            rx_buf_q <= rx_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero otherwise

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                sms_pkg::ADDR_CTRL: rdata <= ctrl_q;
                sms_pkg::ADDR_STAT: rdata <= {done_q, write_collision_flag_q, 5'h00, dbl_q};
                sms_pkg::ADDR_DATA: rdata <= rx_buf_q;
                sms_pkg::ADDR_DIR: rdata <= dir_q;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers; select is only ever driven from software's level

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_out <= 1'b1;
            ss_n_oe <= 1'b0;
        end else begin
            sck_out <= sck_q;
            mosi_out <= dout_q;
            miso_out <= dout_q;
            ss_n_out <= dir_q[sms_pkg::DIR_SS_LEVEL];
            if (enabled && is_master) begin
                sck_oe <= dir_q[sms_pkg::DIR_SCK];
                mosi_oe <= dir_q[sms_pkg::DIR_MOSI];
                miso_oe <= 1'b0;
                ss_n_oe <= dir_q[sms_pkg::DIR_SS];
            end else if (enabled) begin
                sck_oe <= 1'b0;
                mosi_oe <= 1'b0;
                ss_n_oe <= 1'b0;
                miso_oe <= dir_q[sms_pkg::DIR_MISO] && slave_sel;
            end else begin
                sck_oe <= 1'b0;
                mosi_oe <= 1'b0;
                miso_oe <= 1'b0;
                ss_n_oe <= 1'b0;
            end
        end
    end

endmodule : sms_top

`default_nettype wire

//--- sim/sms_checker.sv
`timescale 1ns/1ps
`default_nettype none

module sms_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_in,
    input wire logic ss_n_out,
    input wire logic ss_n_oe,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic ien_q;
    wire logic ctrl_wr = wr && addr == sms_pkg::ADDR_CTRL;
    wire logic dir_wr = wr && addr == sms_pkg::ADDR_DIR;
    wire logic data_rd = rd && addr == sms_pkg::ADDR_DATA;
    wire logic stat_rd = rd && addr == sms_pkg::ADDR_STAT;

    // Shadow of the interrupt enable; a mode fault never touches it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ien_q <= 1'b0;
        end else if (ctrl_wr) begin
            ien_q <= wdata[sms_pkg::CTRL_IRQ_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_irq_en;
        irq |-> ien_q || $past(ien_q);
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("irq high while disabled");
    property p_master_miso;
        sck_oe |-> !miso_oe;
    endproperty
    a_master_miso: assert property (p_master_miso)
        else $error("miso driven in master");
    property p_slave_idle;
        ss_n_in [*5] |-> !miso_oe;
    endproperty
    a_slave_idle: assert property (p_slave_idle)
        else $error("miso driven while deselected");
    property p_ss_level;
        dir_wr ##1 !dir_wr |-> ##1 ss_n_out == $past(wdata[sms_pkg::DIR_SS_LEVEL], 2);
    endproperty
    a_ss_level: assert property (p_ss_level)
        else $error("select level not software set");
    property p_status_rsvd;
        $past(stat_rd) |-> rdata[5:1] == 5'h00;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd)
        else $error("reserved status bits set");
    property p_disable_oe;
        ctrl_wr && !wdata[sms_pkg::CTRL_ENABLE] ##1 !ctrl_wr
            |-> ##1 !(mosi_oe || miso_oe || sck_oe || ss_n_oe);
    endproperty
    a_disable_oe: assert property (p_disable_oe)
        else $error("pin driven while disabled");
    property p_rx_hold;
        data_rd ##1 (data_rd && ss_n_in && !sck_oe) |=> rdata == $past(rdata);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("receive buffer changed idle");
    property p_dbl_rb;
        wr && addr == sms_pkg::ADDR_STAT ##1 stat_rd
            |=> rdata[sms_pkg::STAT_DBL] == $past(wdata[sms_pkg::STAT_DBL], 2);
    endproperty
    a_dbl_rb: assert property (p_dbl_rb)
        else $error("double speed bit lost");
    c_irq: cover property ($rose(irq));
    c_slave: cover property ($rose(miso_oe));
    c_master: cover property ($rose(sck_out) && sck_oe);
endmodule : sms_checker

bind sms_top sms_checker u_chk (
    .ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .sck_out, .sck_oe,
    .mosi_oe, .miso_oe, .ss_n_in, .ss_n_out, .ss_n_oe, .irq
);

`default_nettype wire

//--- sim/sms_remote.sv
`timescale 1ns/1ps
`default_nettype none

module sms_remote (
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic clock_idle_level,
    input wire logic clock_sample_edge,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic bit_q;
    // Rises on the sample edge in all four modes
    wire logic smp = sck ^ clock_idle_level ^ clock_sample_edge;
    // Released line shows the inverse so a stale bit cannot pass
    assign miso = ss_n ? ~bit_q : bit_q;

    initial begin
        bit_q = 1'b0;
        tx_q = 8'h00;
        rx_q = 8'h00;
        rx_byte = 8'h00;
    end
    // Select low opens a packet and reloads the shifter
    always @(negedge ss_n) begin
        tx_q = tx_byte;
        if (!clock_sample_edge) begin
            bit_q = tx_q[7];
            tx_q = tx_q << 1;
        end
    end
    // Out on the setup edge, and at select low when sampling on the leading edge, so the bit holds across sampling
    always @(negedge smp) begin
        if (!ss_n) begin
            bit_q = tx_q[7];
            tx_q = tx_q << 1;
        end
    end
    always @(posedge smp) begin
        if (!ss_n) begin
            rx_q = {rx_q[6:0], mosi};
            rx_byte = rx_q;
        end
    end
endmodule : sms_remote

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic ref_clk, rst, wr, rd, tb_sck, tb_mosi, tb_ss_n, p_en, p_clock_idle_level, p_clock_sample_edge;
    logic [1:0] addr;
    logic [7:0] wdata, p_tx, got, g2;
    logic [2:0] s;
    wire logic [7:0] rdata, p_rx;
    wire logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    wire logic ss_n_out, ss_n_oe, irq, p_miso;
    int n_errors, checked, n;
    int hv [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    // Each line is driven by whoever holds its enable
    wire logic sck_l = sck_oe ? sck_out : tb_sck;
    wire logic mosi_l = mosi_oe ? mosi_out : tb_mosi;
    wire logic miso_l = miso_oe ? miso_out : p_miso;
    wire logic ss_l = ss_n_oe ? ss_n_out : tb_ss_n;
    wire logic p_ss = ss_l | ~p_en;

    sms_top dut (
        .ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .sck_in(sck_l), .sck_out,
        .sck_oe, .mosi_in(mosi_l), .mosi_out, .mosi_oe, .miso_in(miso_l), .miso_out,
        .miso_oe, .ss_n_in(ss_l), .ss_n_out, .ss_n_oe, .irq
    );
    sms_remote partner (
        .sck(sck_l), .mosi(mosi_l), .ss_n(p_ss), .clock_idle_level(p_clock_idle_level), .clock_sample_edge(p_clock_sample_edge),
        .tx_byte(p_tx), .miso(p_miso), .rx_byte(p_rx)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string what);
        checked++;
        if (act !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, act, exp);
        end
    endtask : chk
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wreg
    task automatic rreg(input logic [1:0] a, output logic [7:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        d = rdata;
    endtask : rreg
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 3000) begin
            n_errors++;
            $display("CHECK FAILED %0t irq timeout", $time);
            report_and_stop;
        end
    endtask : wait_irq
    // Remote master in mode 0; a 12-cycle period covers the slave's turnaround
    task automatic spi_bits(input logic [7:0] d, input int nb, output logic [7:0] g);
        g = 8'h00;
        for (int k = 0; k < nb; k++) begin
            tb_mosi <= d[7-k];
            repeat (6) @(posedge ref_clk);
            tb_sck <= 1'b1;
            g = {g[6:0], miso_l};
            repeat (6) @(posedge ref_clk);
            tb_sck <= 1'b0;
        end
        tb_mosi <= ~tb_mosi;
        // Let the slave see the last trailing edge before software acts
        repeat (4) @(posedge ref_clk);
    endtask : spi_bits
    function automatic logic [7:0] rev(input logic [7:0] d);
        logic [7:0] r;
        for (int k = 0; k < 8; k++) begin
            r[k] = d[7-k];
        end
        return r;
    endfunction : rev

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, tb_ss_n, p_en} = 3'b111;
        {wr, rd, tb_sck, tb_mosi, p_clock_idle_level, p_clock_sample_edge} = 6'h00;
        {addr, wdata, p_tx} = 18'h0_0000;
        n_errors = 0;
        checked = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rreg(2'(a), got);
            chk(got, a == 3 ? sms_pkg::DIR_RESET : 8'h00, "reset value");
        end
        chk({7'h00, ss_n_out}, 8'h01, "select idle");
        wreg(sms_pkg::ADDR_DIR, 8'h1D);
        // Every divisor, mode and bit order against the remote slave
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            p_clock_idle_level <= s[1];
            p_clock_sample_edge <= s[0];
            p_tx <= 8'h3C + 8'(i);
            wreg(sms_pkg::ADDR_CTRL, {3'b110 | {2'b00, s[2]}, 1'b1, s[1:0], s[1:0]});
            wr <= 1'b1;
            addr <= sms_pkg::ADDR_STAT;
            wdata <= {7'h00, s[2]};
            @(posedge ref_clk);
            wr <= 1'b0;
            rd <= 1'b1;
            @(posedge ref_clk);
            rd <= 1'b0;
            @(posedge ref_clk);
            chk(rdata, {7'h00, s[2]}, "double speed bit");
            chk({7'h00, sck_out}, {7'h00, s[1]}, "clock idle level");
            wreg(sms_pkg::ADDR_DIR, 8'h0D);
            wreg(sms_pkg::ADDR_DATA, 8'hA0 ^ 8'(i));
            wait_irq;
            chk({7'h00, n >= hv[i] * 16 - 2 && n <= hv[i] * 16 + 6}, 8'h01, "rate");
            chk(p_rx, s[2] ? rev(8'hA0 ^ 8'(i)) : 8'hA0 ^ 8'(i), "mosi byte");
            rreg(sms_pkg::ADDR_STAT, got);
            chk(got, {1'b1, 6'h00, s[2]}, "done flag");
            rreg(sms_pkg::ADDR_DATA, got);
            chk(got, s[2] ? rev(p_tx) : p_tx, "miso byte");
            @(posedge ref_clk);
            chk({7'h00, irq}, 8'h00, "flag clear");
            wreg(sms_pkg::ADDR_DIR, 8'h1D);
        end
        wreg(sms_pkg::ADDR_DIR, 8'h0D);
        wreg(sms_pkg::ADDR_DATA, 8'h35);
        wreg(sms_pkg::ADDR_DATA, 8'hC3);
        wait_irq;
        chk(p_rx, rev(8'h35), "collided write ignored");
        rreg(sms_pkg::ADDR_STAT, got);
        chk(got, 8'hC1, "collision flag");
        rreg(sms_pkg::ADDR_DATA, got);
        rreg(sms_pkg::ADDR_STAT, got);
        chk(got, 8'h01, "flags cleared");
        // Select as input pulled low by another master
        wreg(sms_pkg::ADDR_DIR, 8'h15);
        tb_ss_n <= 1'b0;
        wait_irq;
        tb_ss_n <= 1'b1;
        rreg(sms_pkg::ADDR_CTRL, got);
        chk(got, 8'hEF, "master dropped");
        rreg(sms_pkg::ADDR_STAT, got);
        chk(got, 8'h81, "fault done");
        rreg(sms_pkg::ADDR_DATA, got);
        p_en <= 1'b0;
        wreg(sms_pkg::ADDR_DIR, 8'h02);
        wreg(sms_pkg::ADDR_CTRL, 8'hC0);
        wreg(sms_pkg::ADDR_DATA, 8'h96);
        chk({7'h00, miso_oe}, 8'h00, "slave undriven");
        tb_ss_n <= 1'b0;
        spi_bits(8'h5B, 8, got);
        chk(got, 8'h96, "slave sent");
        wait_irq;
        wreg(sms_pkg::ADDR_DATA, 8'h11);
        spi_bits(8'hE7, 8, got);
        chk(got, 8'h11, "slave second");
        rreg(sms_pkg::ADDR_STAT, got);
        chk(got, 8'h81, "slave status");
        tb_ss_n <= 1'b1;
        rd <= 1'b1;
        addr <= sms_pkg::ADDR_DATA;
        repeat (2) @(posedge ref_clk);
        got = rdata;
        rd <= 1'b0;
        @(posedge ref_clk);
        chk(got, 8'hE7, "older byte lost");
        chk(rdata, 8'hE7, "byte held");
        tb_ss_n <= 1'b0;
        spi_bits(8'hFF, 3, got);
        tb_ss_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tb_ss_n <= 1'b0;
        spi_bits(8'h42, 8, g2);
        wait_irq;
        tb_ss_n <= 1'b1;
        rreg(sms_pkg::ADDR_DATA, got);
        chk(got, 8'h42, "resync on select");
        chk(g2, 8'h11, "resent after resync");
        wreg(sms_pkg::ADDR_DIR, 8'h0F);
        wreg(sms_pkg::ADDR_CTRL, 8'h50);
        @(posedge ref_clk);
        chk({4'h0, mosi_oe, miso_oe, sck_oe, ss_n_oe}, 8'h0B, "master pins");
        wreg(sms_pkg::ADDR_CTRL, 8'h00);
        @(posedge ref_clk);
        chk({4'h0, mosi_oe, miso_oe, sck_oe, ss_n_oe}, 8'h00, "disabled pins");
        report_and_stop;
    end
endmodule : testbench

`default_nettype wire
